/* File: rtl/sct_system_counter_timer.sv */
// Purpose: system counter, per-core timers, per-core interrupt map and
//          the wakeup timer with its secured frame access port
// Assumes: all inputs synchronous to sys_clk; rst synchronous active high
// Notes:   per-core lines are indexed by interrupt number, bits 0..18 and 31 zero
//
// Notes on behaviour
// - non-secure physical timer on line 30, secure physical on 29
// - hypervisor virtual timer on 28 when supported, virtual timer on 27
// - hypervisor physical timer on line 26
// - list overflow maintenance event on line 25
// - cross-trigger interrupt on line 24
// - performance monitor overflow on line 23
// - debug channel interrupt on line 22
// - profiling buffer interrupt on line 21 when profiling exists
// - secure hypervisor physical on 20, secure hypervisor virtual on 19
// - counter ticks at no less than 10 MHz
// - width and rate together avoid wrap within ten years
// - counter is between 56 and 64 bits wide
// - counter is a full 64 bits for scaling support
// - count is distributed and valid while core timers are powered
// - each core timer raises its own core's line on expiry
// - a memory-mapped wakeup timer exists for powered-down cores
// - wakeup expiry goes out as shared line or message interrupt
// - virtual offset reads zero, writes to it are dropped
// - frames: timer non-secure, counter control secure, timer control both
`timescale 1ns/1ps
`default_nettype none
module sct_system_counter_timer
  import sct_pkg::*;
(
  input  wire logic                                 sys_clk,
  input  wire logic                                 rst,
  input  wire logic [SCT_CORES-1:0]                 core_timer_powered,
  input  wire logic [SCT_CORES-1:0][SCT_TIMERS-1:0][SCT_CNT_W-1:0] timer_cmp_value,
  input  wire logic [SCT_CORES-1:0][SCT_TIMERS-1:0] timer_enable,
  input  wire logic [SCT_CORES-1:0][SCT_TIMERS-1:0] timer_imask,
  input  wire logic [SCT_CORES-1:0][SCT_CNT_W-1:0]  virt_offset,
  input  wire logic [SCT_CORES-1:0]                 maint_event,
  input  wire logic [SCT_CORES-1:0]                 cross_trigger_irq,
  input  wire logic [SCT_CORES-1:0]                 perfmon_overflow,
  input  wire logic [SCT_CORES-1:0]                 debug_channel_irq,
  input  wire logic [SCT_CORES-1:0]                 profiling_buffer_irq,
  input  wire logic                                 frame_req,
  input  wire logic                                 frame_write,
  input  wire logic [1:0]                           frame_sel,
  input  wire logic                                 frame_secure,
  input  wire logic [11:0]                          frame_addr,
  input  wire logic [31:0]                          frame_wdata,
  output logic                                      frame_ack,
  output logic                                      frame_denied,
  output logic [31:0]                               frame_rdata,
  output logic [SCT_CNT_W-1:0]                      count_out,
  output logic [SCT_CORES-1:0]                      count_valid,
  output logic [SCT_CORES-1:0][SCT_TIMERS-1:0]      timer_status,
  output logic [SCT_CORES-1:0][SCT_LINES-1:0]       per_core_interrupt,
  output logic                                      wake_shared_irq,
  output logic                                      wake_message_req
);
  // ----------------------------------------------------------------
  // build-time checks on the counter choice
  // ----------------------------------------------------------------
  // an illegal width or rate stops elaboration instead of misbehaving
  if (SCT_TICK_HZ < SCT_MIN_HZ) begin : g_rate_bad
    $error("tick rate below minimum");
  end
  if (SCT_CNT_W < SCT_CNT_MIN_W || SCT_CNT_W > SCT_CNT_MAX_W) begin : g_w_bad
    $error("counter width out of range");
  end
  if (SCT_CNT_W != 64) begin : g_scale_bad
    $error("scaling needs a full width counter");
  end
  if (SCT_CNT_W < 64 && (SCT_TEN_YEAR_TICKS >> SCT_CNT_W) != 0)
  begin : g_wrap_bad
    $error("counter would wrap inside ten years");
  end

  // ----------------------------------------------------------------
  // system counter
  // ----------------------------------------------------------------
  logic [7:0]           div_reg;
  logic                 tick;
  logic [SCT_CNT_W-1:0] cnt_reg;
  logic                 cnt_en_reg;
  logic                 cv_lo_wr;
  logic                 cv_hi_wr;

  // divider makes the tick; the counter holds its rate through it
  always_ff @(posedge sys_clk) begin
    if (rst || !cnt_en_reg || div_reg == 8'(SCT_TICK_DIV - 1)) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end
  assign tick = cnt_en_reg && (div_reg == 8'(SCT_TICK_DIV - 1));

  // software loads win over a tick in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (cv_lo_wr) begin
      cnt_reg[31:0] <= frame_wdata;
    end else if (cv_hi_wr) begin
      cnt_reg[63:32] <= frame_wdata;
    end else if (tick) begin
      cnt_reg <= cnt_reg + 64'h1;
    end
  end

  // ----------------------------------------------------------------
  // count distribution
  // ----------------------------------------------------------------
  // one registered copy feeds every core; valid follows core power
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_out   <= '0;
      count_valid <= '0;
    end else begin
      count_out   <= cnt_reg;
      count_valid <= core_timer_powered;
    end
  end

  // ----------------------------------------------------------------
  // per-core timers
  // ----------------------------------------------------------------
  logic [SCT_CORES-1:0][SCT_TIMERS-1:0] tmr_irq;

  for (genvar c = 0; c < SCT_CORES; c++) begin : g_core
    for (genvar t = 0; t < SCT_TIMERS; t++) begin : g_tmr
      localparam bit IS_VIRT = (t == SCT_T_VIRT) || (t == SCT_T_HYP_VIRT)
                               || (t == SCT_T_S_HYP_VIR);
      // a powered-down timer must not fire on a count it cannot see
      sct_core_timer u_tmr (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .count     (count_out),
        .offset    (IS_VIRT ? virt_offset[c] : 64'h0),
        .cmp_value (timer_cmp_value[c][t]),
        .enable    (timer_enable[c][t] && count_valid[c]),
        .imask     (timer_imask[c][t]),
        .status    (timer_status[c][t]),
        .irq       (tmr_irq[c][t])
      );
    end
  end

  // ----------------------------------------------------------------
  // per-core interrupt line map
  // ----------------------------------------------------------------
  // each core's lines come only from that core's own sources
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      per_core_interrupt <= '0;
    end else begin
      for (int c = 0; c < SCT_CORES; c++) begin
        per_core_interrupt[c] <= '0;
        per_core_interrupt[c][SCT_ID_NS_PHYS] <= tmr_irq[c][SCT_T_NS_PHYS];
        per_core_interrupt[c][SCT_ID_S_PHYS]  <= tmr_irq[c][SCT_T_S_PHYS];
        per_core_interrupt[c][SCT_ID_HYP_VIRT] <=
          SCT_HAS_HYP_VIRT && tmr_irq[c][SCT_T_HYP_VIRT];
        per_core_interrupt[c][SCT_ID_VIRT] <= tmr_irq[c][SCT_T_VIRT];
        per_core_interrupt[c][SCT_ID_HYP_PHYS] <= tmr_irq[c][SCT_T_HYP_PHYS];
        per_core_interrupt[c][SCT_ID_MAINT]   <= maint_event[c];
        per_core_interrupt[c][SCT_ID_XTRIG]   <= cross_trigger_irq[c];
        per_core_interrupt[c][SCT_ID_PERFMON] <= perfmon_overflow[c];
        per_core_interrupt[c][SCT_ID_DEBUG]   <= debug_channel_irq[c];
        per_core_interrupt[c][SCT_ID_PROFILE] <=
          SCT_HAS_PROFILE && profiling_buffer_irq[c];
        per_core_interrupt[c][SCT_ID_S_HYP_PHY] <=
          SCT_HAS_SEC_HYP && tmr_irq[c][SCT_T_S_HYP_PHY];
        per_core_interrupt[c][SCT_ID_S_HYP_VIR] <=
          SCT_HAS_SEC_HYP && tmr_irq[c][SCT_T_S_HYP_VIR];
      end
    end
  end

  // ----------------------------------------------------------------
  // frame access security
  // ----------------------------------------------------------------
  logic allowed;
  logic acc_ok;

  // the read frame is optional and, when present, open to both spaces
  always_comb begin
    case (sct_frame_t'(frame_sel))
      SCT_FR_CNT_CTRL: allowed = frame_secure;
      SCT_FR_CNT_READ: allowed = SCT_HAS_RD_FRAME;
      SCT_FR_TMR_CTRL: allowed = 1'b1;
      SCT_FR_TIMER:    allowed = !frame_secure;
      default:         allowed = 1'b0;
    endcase
  end
  assign acc_ok = frame_req && allowed;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic wk_lo_wr;
  logic wk_hi_wr;
  logic wk_ctl_wr;
  logic cr_wr;

  assign cr_wr    = acc_ok && frame_write && frame_sel == SCT_FR_CNT_CTRL
                    && frame_addr == SCT_OFF_CNT_CR;
  assign cv_lo_wr = acc_ok && frame_write && frame_sel == SCT_FR_CNT_CTRL
                    && frame_addr == SCT_OFF_CNT_CV_LO;
  assign cv_hi_wr = acc_ok && frame_write && frame_sel == SCT_FR_CNT_CTRL
                    && frame_addr == SCT_OFF_CNT_CV_HI;
  assign wk_lo_wr = acc_ok && frame_write && frame_sel == SCT_FR_TIMER
                    && frame_addr == SCT_OFF_CVAL_LO;
  assign wk_hi_wr = acc_ok && frame_write && frame_sel == SCT_FR_TIMER
                    && frame_addr == SCT_OFF_CVAL_HI;
  assign wk_ctl_wr = acc_ok && frame_write && frame_sel == SCT_FR_TIMER
                     && frame_addr == SCT_OFF_CTL;
  // virtual offset writes in the timer control frame decode to nothing

  // counter enable lives in the control register of the secure frame
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_en_reg <= 1'b0;
    end else if (cr_wr) begin
      cnt_en_reg <= frame_wdata[SCT_CR_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // wakeup timer
  // ----------------------------------------------------------------
  logic [SCT_CNT_W-1:0] wk_cval_reg;
  logic                 wk_en_reg;
  logic                 wk_msk_reg;
  logic                 wk_status;

  // compare value resets to all ones so nothing fires before setup
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wk_cval_reg <= '1;
      wk_en_reg   <= 1'b0;
      wk_msk_reg  <= 1'b0;
    end else begin
      if (wk_lo_wr) begin
        wk_cval_reg[31:0] <= frame_wdata;
      end
      if (wk_hi_wr) begin
        wk_cval_reg[63:32] <= frame_wdata;
      end
      if (wk_ctl_wr) begin
        wk_en_reg  <= frame_wdata[SCT_CTL_EN_BIT];
        wk_msk_reg <= frame_wdata[SCT_CTL_MSK_BIT];
      end
    end
  end

  // always present: core timers here are not assumed always on
  sct_wake_timer u_wake (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .count       (cnt_reg),
    .cmp_value   (wk_cval_reg),
    .enable      (wk_en_reg),
    .imask       (wk_msk_reg),
    .status      (wk_status),
    .shared_irq  (wake_shared_irq),
    .message_req (wake_message_req)
  );

  // ----------------------------------------------------------------
  // read path and access answer
  // ----------------------------------------------------------------
  logic [31:0] rd_next;

  // unmapped offsets and the virtual offset read as zero
  always_comb begin
    rd_next = SCT_ZERO_W;
    case (sct_frame_t'(frame_sel))
      SCT_FR_CNT_CTRL: begin
        if (frame_addr == SCT_OFF_CNT_CR) rd_next = {31'h0, cnt_en_reg};
        if (frame_addr == SCT_OFF_CNT_SR) rd_next = SCT_ZERO_W;
        if (frame_addr == SCT_OFF_CNT_CV_LO) rd_next = cnt_reg[31:0];
        if (frame_addr == SCT_OFF_CNT_CV_HI) rd_next = cnt_reg[63:32];
      end
      SCT_FR_CNT_READ: begin
        if (frame_addr == SCT_OFF_RD_CV_LO) rd_next = cnt_reg[31:0];
        if (frame_addr == SCT_OFF_RD_CV_HI) rd_next = cnt_reg[63:32];
      end
      SCT_FR_TMR_CTRL: begin
        rd_next = SCT_ZERO_W;
      end
      SCT_FR_TIMER: begin
        if (frame_addr == SCT_OFF_PCT_LO) rd_next = cnt_reg[31:0];
        if (frame_addr == SCT_OFF_PCT_HI) rd_next = cnt_reg[63:32];
        if (frame_addr == SCT_OFF_CVAL_LO) rd_next = wk_cval_reg[31:0];
        if (frame_addr == SCT_OFF_CVAL_HI) rd_next = wk_cval_reg[63:32];
        if (frame_addr == SCT_OFF_CTL) begin
          rd_next = {29'h0, wk_status, wk_msk_reg, wk_en_reg};
        end
      end
      default: rd_next = SCT_ZERO_W;
    endcase
  end

  // every request is answered next cycle; a refused one reads zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_ack    <= 1'b0;
      frame_denied <= 1'b0;
      frame_rdata  <= '0;
    end else begin
      frame_ack    <= frame_req;
      frame_denied <= frame_req && !allowed;
      frame_rdata  <= (acc_ok && !frame_write) ? rd_next : SCT_ZERO_W;
    end
  end
endmodule
`default_nettype wire

/* File: include/sct_pkg.sv */
// Purpose: shared constants for the system counter and timer block
// Assumes: 100 MHz sys_clk, counter ticks derived from it by a divider
// Notes:   per-core interrupt numbers and frame offsets are fixed here
package sct_pkg;
  // ----------------------------------------------------------------
  // clock and counter
  // ----------------------------------------------------------------
  localparam longint SCT_SYS_HZ    = 100000000;
  localparam longint SCT_TICK_HZ   = 50000000;  // at least the minimum
  localparam longint SCT_MIN_HZ    = 10000000;
  localparam int     SCT_TICK_DIV  = int'(SCT_SYS_HZ / SCT_TICK_HZ);
  localparam int     SCT_CNT_W     = 64;        // full width, scaling capable
  localparam int     SCT_CNT_MIN_W = 56;
  localparam int     SCT_CNT_MAX_W = 64;
  localparam logic [63:0] SCT_TEN_YEARS_S  = 64'd315360000;
  localparam logic [63:0] SCT_TEN_YEAR_TICKS =
    SCT_TEN_YEARS_S * 64'(SCT_TICK_HZ);
  // ----------------------------------------------------------------
  // cores, timers and per-core interrupt numbers
  // ----------------------------------------------------------------
  localparam int SCT_CORES  = 2;
  localparam int SCT_TIMERS = 7;
  localparam int SCT_LINES  = 32;
  localparam bit SCT_HAS_HYP_VIRT = 1'b1;
  localparam bit SCT_HAS_SEC_HYP  = 1'b1;
  localparam bit SCT_HAS_PROFILE  = 1'b1;
  localparam bit SCT_HAS_RD_FRAME = 1'b1;
  localparam bit SCT_WAKE_AS_MSG  = 1'b0;    // 0: shared line, 1: message
  localparam int SCT_T_NS_PHYS   = 0;
  localparam int SCT_T_S_PHYS    = 1;
  localparam int SCT_T_HYP_VIRT  = 2;
  localparam int SCT_T_VIRT      = 3;
  localparam int SCT_T_HYP_PHYS  = 4;
  localparam int SCT_T_S_HYP_PHY = 5;
  localparam int SCT_T_S_HYP_VIR = 6;
  localparam int SCT_ID_NS_PHYS   = 30;
  localparam int SCT_ID_S_PHYS    = 29;
  localparam int SCT_ID_HYP_VIRT  = 28;
  localparam int SCT_ID_VIRT      = 27;
  localparam int SCT_ID_HYP_PHYS  = 26;
  localparam int SCT_ID_MAINT     = 25;
  localparam int SCT_ID_XTRIG     = 24;
  localparam int SCT_ID_PERFMON   = 23;
  localparam int SCT_ID_DEBUG     = 22;
  localparam int SCT_ID_PROFILE   = 21;
  localparam int SCT_ID_S_HYP_PHY = 20;
  localparam int SCT_ID_S_HYP_VIR = 19;
  // ----------------------------------------------------------------
  // counter and wakeup timer frames and offsets
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCT_FR_CNT_CTRL = 2'h0,
    SCT_FR_CNT_READ = 2'h1,
    SCT_FR_TMR_CTRL = 2'h2,
    SCT_FR_TIMER    = 2'h3
  } sct_frame_t;
  localparam logic [11:0] SCT_OFF_CNT_CR    = 12'h000;
  localparam logic [11:0] SCT_OFF_CNT_SR    = 12'h004;
  localparam logic [11:0] SCT_OFF_CNT_CV_LO = 12'h008;
  localparam logic [11:0] SCT_OFF_CNT_CV_HI = 12'h00c;
  localparam logic [11:0] SCT_OFF_RD_CV_LO  = 12'h000;
  localparam logic [11:0] SCT_OFF_RD_CV_HI  = 12'h004;
  localparam logic [11:0] SCT_OFF_VOFF_LO   = 12'h080;
  localparam logic [11:0] SCT_OFF_VOFF_HI   = 12'h084;
  localparam logic [11:0] SCT_OFF_PCT_LO    = 12'h000;
  localparam logic [11:0] SCT_OFF_PCT_HI    = 12'h004;
  localparam logic [11:0] SCT_OFF_CVAL_LO   = 12'h020;
  localparam logic [11:0] SCT_OFF_CVAL_HI   = 12'h024;
  localparam logic [11:0] SCT_OFF_CTL       = 12'h02c;
  localparam int SCT_CR_EN_BIT   = 0;
  localparam int SCT_CTL_EN_BIT  = 0;
  localparam int SCT_CTL_MSK_BIT = 1;
  localparam int SCT_CTL_ST_BIT  = 2;
  localparam logic [31:0] SCT_ZERO_W = 32'h0000_0000;
endpackage

/* File: rtl/sct_core_timer.sv */
// Purpose: one compare timer against the distributed count
// Assumes: count advances monotonically, offset applies to virtual views
// Notes:   status and interrupt are registered, one cycle after the compare
`timescale 1ns/1ps
`default_nettype none
module sct_core_timer
  import sct_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic [SCT_CNT_W-1:0] count,
  input  wire logic [SCT_CNT_W-1:0] offset,
  input  wire logic [SCT_CNT_W-1:0] cmp_value,
  input  wire logic                 enable,
  input  wire logic                 imask,
  output logic                      status,
  output logic                      irq
);
  logic [SCT_CNT_W-1:0] view;

  // ----------------------------------------------------------------
  // expiry
  // ----------------------------------------------------------------
  // a virtual view subtracts its offset; physical timers pass zero
  assign view = count - offset;

  // expiry is a level: it holds while the view is at or past the value
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status <= 1'b0;
      irq    <= 1'b0;
    end else begin
      status <= enable && (view >= cmp_value);
      irq    <= enable && !imask && (view >= cmp_value);
    end
  end
endmodule
`default_nettype wire

/* File: rtl/sct_wake_timer.sv */
// Purpose: memory-mapped wakeup timer compare and interrupt delivery
// Assumes: compare value and control come from the frame logic
// Notes:   no virtual timer; delivery form chosen by a package constant
`timescale 1ns/1ps
`default_nettype none
module sct_wake_timer
  import sct_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic [SCT_CNT_W-1:0] count,
  input  wire logic [SCT_CNT_W-1:0] cmp_value,
  input  wire logic                 enable,
  input  wire logic                 imask,
  output logic                      status,
  output logic                      shared_irq,
  output logic                      message_req
);
  logic fire;
  logic fire_reg;

  assign fire = enable && !imask && (count >= cmp_value);

  // ----------------------------------------------------------------
  // delivery
  // ----------------------------------------------------------------
  // a message is sent once per rising expiry, a shared line is a level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status      <= 1'b0;
      fire_reg    <= 1'b0;
      shared_irq  <= 1'b0;
      message_req <= 1'b0;
    end else begin
      status      <= enable && (count >= cmp_value);
      fire_reg    <= fire;
      shared_irq  <= !SCT_WAKE_AS_MSG && fire;
      message_req <= SCT_WAKE_AS_MSG && fire && !fire_reg;
    end
  end
endmodule
`default_nettype wire

/* File: verification/sct_irq_sink.sv */
// Purpose: interrupt controller stand-in that latches every line seen high
// Assumes: lines are levels synchronous to sys_clk
// Notes:   no acknowledge path, so pending bits clear only through clr
`timescale 1ns/1ps
`default_nettype none
module sct_irq_sink
  import sct_pkg::*;
(
  input  wire logic                               sys_clk,
  input  wire logic                               clr,
  input  wire logic [SCT_CORES-1:0][SCT_LINES-1:0] lines,
  input  wire logic                               wake_line,
  output logic [SCT_CORES-1:0][SCT_LINES-1:0]      seen,
  output logic                                    wake_seen
);
  // sticky pending, so a short pulse on any line is never missed
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      seen <= '0;
      wake_seen <= 1'b0;
    end else begin
      seen <= seen | lines;
      wake_seen <= wake_seen | wake_line;
    end
  end
endmodule
`default_nettype wire

/* File: verification/sct_system_counter_timer_assertions.sv */
// Purpose: port checks on frame access, counter steps and line map
// Assumes: one clock domain, rst synchronous active high
// Notes:   counter steps checked only away from frame traffic
`timescale 1ns/1ps
`default_nettype none
module sct_counter_assertions
  import sct_pkg::*;
(
  input wire logic                                 sys_clk,
  input wire logic                                 rst,
  input wire logic [SCT_CORES-1:0]                 core_timer_powered,
  input wire logic [SCT_CORES-1:0]                 maint_event,
  input wire logic [SCT_CORES-1:0]                 cross_trigger_irq,
  input wire logic                                 frame_req,
  input wire logic [1:0]                           frame_sel,
  input wire logic                                 frame_secure,
  input wire logic                                 frame_ack,
  input wire logic                                 frame_denied,
  input wire logic [31:0]                          frame_rdata,
  input wire logic [SCT_CNT_W-1:0]                 count_out,
  input wire logic [SCT_CORES-1:0][SCT_TIMERS-1:0] timer_status,
  input wire logic [SCT_CORES-1:0][SCT_LINES-1:0]  per_core_interrupt,
  input wire logic                                 wake_message_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_ctrl_ns;
    frame_req && frame_sel == 2'h0 && !frame_secure;
  endsequence
  sequence s_timer_sec;
    frame_req && frame_sel == 2'h3 && frame_secure;
  endsequence
  sequence s_bus_quiet;
    !frame_req [*3];
  endsequence
  a_ack_next: assert property (frame_req |=> frame_ack)
    else $error("frame ack missing");
  a_ack_only: assert property (!frame_req |=> !frame_ack)
    else $error("stray frame ack");
  a_ctrl_secure: assert property (s_ctrl_ns |=> frame_denied && frame_rdata == 32'h0)
    else $error("counter control open to non-secure");
  a_timer_nonsec: assert property (s_timer_sec |=> frame_denied)
    else $error("timer frame open to secure");
  a_tctl_both: assert property (frame_req && frame_sel == 2'h2 |=>
    !frame_denied && frame_rdata == 32'h0)
    else $error("timer control frame refused or nonzero");
  a_count_step: assert property (s_bus_quiet ##0 $changed(count_out) |->
    count_out == $past(count_out) + 64'h1)
    else $error("count did not step by one");
  a_unpowered_quiet: assert property ((!core_timer_powered[0]) [*4] |->
    timer_status[0] == '0 && (per_core_interrupt[0][30:19] & 12'hf83) == 12'h0)
    else $error("unpowered core timer fired");
  a_xtrig_line: assert property ($rose(cross_trigger_irq[0]) |=> per_core_interrupt[0][24])
    else $error("cross trigger line late");
  a_maint_line: assert property (maint_event[1] |=> per_core_interrupt[1][25])
    else $error("maintenance line missing");
  a_unused_low: assert property (per_core_interrupt[0][18:0] == 19'h0 &&
    !per_core_interrupt[0][31] && !wake_message_req)
    else $error("unassigned line or message raised");
endmodule
bind sct_system_counter_timer sct_counter_assertions u_chk (.sys_clk, .rst,
  .core_timer_powered, .maint_event, .cross_trigger_irq, .frame_req, .frame_sel,
  .frame_secure, .frame_ack, .frame_denied, .frame_rdata, .count_out, .timer_status,
  .per_core_interrupt, .wake_message_req);
`default_nettype wire

/* File: verification/system_counter_timer_irq_map_tb.sv */
// Purpose: self-checking bench for line map, frames, counter and wakeup
// Assumes: inputs change 1 ns after the rising edge
// Notes:   compare values and masks stay zero except where a test sets them
`timescale 1ns/1ps
`default_nettype none
module system_counter_timer_irq_map_tb;
  import sct_pkg::*;
  typedef struct {int src; int id;} sct_row_t;
  logic sys_clk, rst, frame_req, frame_write, frame_secure, frame_ack, frame_denied, clr, den;
  logic wake_shared_irq, wake_seen;
  logic [1:0] frame_sel, pw, count_valid;
  logic [11:0] frame_addr;
  logic [31:0] frame_wdata, frame_rdata, rd;
  logic [63:0] count_out;
  logic [4:0][1:0] src;
  logic [1:0][6:0] en, msk;
  logic [1:0][6:0][63:0] cmp;
  logic [1:0][63:0] voff;
  logic [1:0][31:0] per_core_interrupt, seen;
  int num_errors = 0;
  int n_tests = 0;
  // one row per line: timer index or source index plus seven, and its line
  sct_row_t rows [12] = '{'{0, 30}, '{1, 29}, '{2, 28}, '{3, 27}, '{4, 26}, '{5, 20},
    '{6, 19}, '{7, 25}, '{8, 24}, '{9, 23}, '{10, 22}, '{11, 21}};
  sct_system_counter_timer uut (.sys_clk, .rst, .core_timer_powered(pw),
    .timer_cmp_value(cmp), .timer_enable(en), .timer_imask(msk), .virt_offset(voff),
    .maint_event(src[0]), .cross_trigger_irq(src[1]), .perfmon_overflow(src[2]),
    .debug_channel_irq(src[3]), .profiling_buffer_irq(src[4]), .frame_req, .frame_write,
    .frame_sel, .frame_secure, .frame_addr, .frame_wdata, .frame_ack, .frame_denied,
    .frame_rdata, .count_out, .count_valid, .timer_status(), .per_core_interrupt,
    .wake_shared_irq, .wake_message_req());
  sct_irq_sink u_sink (.sys_clk, .clr, .lines(per_core_interrupt),
    .wake_line(wake_shared_irq), .seen, .wake_seen);
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // one access; request held exactly one edge, answer taken 1 ns after that same edge
  task automatic fr(input logic w, input logic [1:0] s, input logic sec,
                    input logic [11:0] a, input logic [31:0] d);
    tick(1);
    {frame_req, frame_write, frame_sel, frame_secure, frame_addr, frame_wdata} = {1'b1, w, s, sec, a, d};
    tick(1);
    chk(frame_ack, 1'b1);
    rd = frame_rdata;
    den = frame_denied;
    frame_req = 0;
  endtask
  task automatic end_of_test;
    $display("errors %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    end_of_test;
  end
  initial begin
    {rst, clr, frame_req, frame_write, frame_secure, frame_sel, frame_addr, frame_wdata} = '0;
    {rst, clr, pw, cmp, en, msk, voff, src} = {2'h3, 2'h3, 896'h0, 14'h0, 14'h0, 128'h0, 10'h0};
    tick(5);
    {rst, clr} = 2'h0;
    foreach (rows[i]) begin
      if (rows[i].src < 7) en[0][rows[i].src] = 1'b1;
      else src[rows[i].src - 7][0] = 1'b1;
      tick(4);
      chk(per_core_interrupt[0], 32'h1 << rows[i].id);
      {en, src} = '0;
      tick(3);
    end
    chk({seen[1], seen[0]}, 64'h7ff8_0000);
    src[1][0] = 1'b1;
    src[0][1] = 1'b1;
    pw[0] = 1'b0;
    en[0][0] = 1'b1;
    tick(6);
    chk({count_valid, per_core_interrupt[0]}, 34'h2_0000_0000 | 34'h100_0000 );
    pw[0] = 1'b1;
    tick(4);
    chk(per_core_interrupt[0][30], 1'b1);
    {en, src} = '0;
    for (int k = 0; k < 8; k++) begin
      fr(0, k[2:1], k[0], 12'h000, 32'h0);
      chk(den, k == 0 || k == 7);
    end
    fr(1, 2'h2, 1, 12'h080, 32'hffff_ffff);
    fr(0, 2'h2, 0, 12'h080, 32'h0);
    chk(rd, 32'h0);
    fr(1, 2'h0, 1, 12'h008, 32'hffff_ffff);
    fr(1, 2'h0, 1, 12'h00c, 32'hffff_ffff);
    fr(0, 2'h1, 0, 12'h004, 32'h0);
    chk(rd, 32'hffff_ffff);
    fr(1, 2'h0, 1, 12'h000, 32'h1);
    tick(6);
    chk({count_out[63:32], count_out < 64'h10}, 33'h1);
    cmp[0][0] = count_out + 64'h20;
    en[0][0] = 1'b1;
    tick(2);
    chk(per_core_interrupt[0][30], 1'b0);
    tick(80);
    chk(per_core_interrupt[0][30], 1'b1);
    en = '0;
    fr(1, 2'h3, 0, 12'h020, count_out[31:0] + 32'h40);
    fr(1, 2'h3, 0, 12'h024, 32'h0);
    fr(1, 2'h3, 0, 12'h02c, 32'h1);
    chk(wake_shared_irq, 1'b0);
    for (int t = 0; t < 400 && wake_seen !== 1'b1; t++) tick(1);
    chk({wake_shared_irq, wake_seen}, 2'h3);
    fr(0, 2'h3, 0, 12'h02c, 32'h0);
    chk(rd, 32'h5);
    fr(1, 2'h3, 0, 12'h02c, 32'h3);
    tick(2);
    chk(wake_shared_irq, 1'b0);
    rst = 1'b1;
    tick(5);
    chk(count_out | per_core_interrupt | 64'(wake_shared_irq), 64'h0);
    rst = 1'b0;
    tick(2);
    end_of_test;
  end
endmodule
`default_nettype wire
